// File: design/led_regs.svh
`ifndef LED_REGS_SVH
`define LED_REGS_SVH

// ----------------------------------------
// Correctable status bit positions
// ----------------------------------------
`define LED_COR_RX_PORT 0
`define LED_COR_BAD_TLP 1
`define LED_COR_BAD_DLLP 2
`define LED_COR_REPLAY_TMR 3
`define LED_COR_REPLAY_ROLL 4
`define LED_COR_W 5

// ----------------------------------------
// Uncorrectable status bit positions
// ----------------------------------------
`define LED_UNC_DL_PROTOCOL 0
`define LED_UNC_W 1

// ----------------------------------------
// Severity summary bit positions
// ----------------------------------------
`define LED_SUM_COR 0
`define LED_SUM_NONFATAL 1
`define LED_SUM_FATAL 2
`define LED_SUM_W 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LED_COR_RST 5'h00
`define LED_UNC_RST 1'h0
`define LED_SUM_RST 3'h0

// ----------------------------------------
// Receive status codes and widths
// ----------------------------------------
`define LED_RXS_W 3
`define LED_RXS_DECODE 3'h4
`define LED_RXS_EB_OVFL 3'h5
`define LED_RXS_EB_UNFL 3'h6
`define LED_RXS_DISPARITY 3'h7
`define LED_SEQ_W 12
`define LED_LANES 8
`define LED_REPLAY_W 2

`endif

// File: design/led_pkg.sv
package led_pkg;

	// Severity class carried with each error event
	typedef enum logic [1:0] {
		LED_CLS_NONE,
		LED_CLS_COR,
		LED_CLS_NONFATAL,
		LED_CLS_FATAL
	} led_class_e;

endpackage

// File: design/led_lane_chk.sv
`timescale 1ns/1ps
`include "led_regs.svh"

module led_lane_chk (
	// Lane receive status
	input wire logic [`LED_RXS_W-1:0] rx_status,
	input wire logic lane_active,
	// Fault flag
	output logic lane_fault
);

	// Only coding sublayer faults of an active lane count
	always_comb begin
		lane_fault = 1'b0;
		if (lane_active) begin
			unique case (rx_status)
				`LED_RXS_DECODE, `LED_RXS_EB_OVFL,
				`LED_RXS_EB_UNFL, `LED_RXS_DISPARITY: lane_fault = 1'b1;
				default: lane_fault = 1'b0;
			endcase
		end
	end

endmodule

// File: design/led_top.sv
`timescale 1ns/1ps
`include "led_regs.svh"

module led_top
	import led_pkg::*;
#(
	parameter int LANES = `LED_LANES,
	parameter int REPLAY_W = `LED_REPLAY_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Physical layer inputs
	input wire logic [LANES*`LED_RXS_W-1:0] rx_status,
	input wire logic [LANES-1:0] lane_active,
	input wire logic deskew_ovfl,
	input wire logic ctrl_sym_bad_lane,
	// Data link layer inputs
	input wire logic tlp_lcrc_bad,
	input wire logic tlp_seq_bad,
	input wire logic dllp_crc_bad,
	input wire logic replay_timeout,
	input wire logic [REPLAY_W-1:0] replay_count,
	input wire logic ack_valid,
	input wire logic [`LED_SEQ_W-1:0] acknowledged_sequence_number,
	input wire logic [`LED_SEQ_W-1:0] last_acked_seq,
	input wire logic [`LED_SEQ_W-1:0] next_tx_seq,
	// Reporting control, clears are write-one pulses
	input wire logic aer_enable,
	input wire logic [`LED_COR_W-1:0] cor_clear,
	input wire logic [`LED_UNC_W-1:0] unc_clear,
	input wire logic [`LED_SUM_W-1:0] sum_clear,
	// Status and events
	output logic [`LED_COR_W-1:0] cor_status_reg,
	output logic [`LED_UNC_W-1:0] unc_status_reg,
	output logic [`LED_SUM_W-1:0] sum_status_reg,
	output logic err_event_reg,
	output led_class_e err_class_reg
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Forward distance between two sequence numbers, modulo the space
	function automatic logic [`LED_SEQ_W-1:0] seq_dist(
		input logic [`LED_SEQ_W-1:0] from_seq,
		input logic [`LED_SEQ_W-1:0] to_seq
	);
		seq_dist = to_seq - from_seq;
	endfunction

	// ----------------------------------------
	// Detection
	// ----------------------------------------

	logic [LANES-1:0] lane_fault;
	logic rx_port_err;
	logic bad_tlp;
	logic bad_dllp;
	logic replay_roll;
	logic dl_protocol_err;
	logic [REPLAY_W-1:0] replay_prev_reg;
	logic [REPLAY_W-1:0] replay_prev_next;
	logic [`LED_SEQ_W-1:0] newest_sent;

	// One checker per lane
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			led_lane_chk u_chk (
				.rx_status(rx_status[gi*`LED_RXS_W +: `LED_RXS_W]),
				.lane_active(lane_active[gi]),
				.lane_fault(lane_fault[gi])
			);
		end
	endgenerate

	// Error conditions from this cycle's inputs, rollover also from last cycle's replay count
	always_comb begin
		newest_sent = next_tx_seq - `LED_SEQ_W'(1);
		rx_port_err = (|lane_fault) || deskew_ovfl || ctrl_sym_bad_lane;
		bad_tlp = tlp_lcrc_bad || tlp_seq_bad;
		bad_dllp = dllp_crc_bad;
		// Wrap is the step from all ones back to zero
		replay_roll = (&replay_prev_reg) && (replay_count == '0);
		replay_prev_next = replay_count;
		// Legal numbers lie from the last acked up to the newest sent
		dl_protocol_err = ack_valid && (seq_dist(last_acked_seq, acknowledged_sequence_number)
			> seq_dist(last_acked_seq, newest_sent));
	end

	// ----------------------------------------
	// Classification and logging
	// ----------------------------------------

	logic [`LED_COR_W-1:0] cor_hit;
	logic [`LED_COR_W-1:0] cor_status_next;
	logic [`LED_UNC_W-1:0] unc_status_next;
	logic [`LED_SUM_W-1:0] sum_status_next;
	logic [`LED_SUM_W-1:0] sum_hit;
	logic err_event_next;
	led_class_e err_class_next;

	// Sticky status with set winning over clear, most severe class reported
	always_comb begin
		cor_hit = '0;
		cor_hit[`LED_COR_RX_PORT] = rx_port_err;
		cor_hit[`LED_COR_BAD_TLP] = bad_tlp;
		cor_hit[`LED_COR_BAD_DLLP] = bad_dllp;
		cor_hit[`LED_COR_REPLAY_TMR] = replay_timeout;
		cor_hit[`LED_COR_REPLAY_ROLL] = replay_roll;
		sum_hit = '0;
		sum_hit[`LED_SUM_COR] = |cor_hit;
		sum_hit[`LED_SUM_FATAL] = dl_protocol_err;
		// Detailed status logs only with advanced reporting on
		cor_status_next = cor_status_reg & ~cor_clear;
		unc_status_next = unc_status_reg & ~unc_clear;
		if (aer_enable) begin
			cor_status_next = cor_status_next | cor_hit;
			unc_status_next[`LED_UNC_DL_PROTOCOL] = unc_status_next[`LED_UNC_DL_PROTOCOL]
				| dl_protocol_err;
		end
		// Baseline severity summary always logs
		sum_status_next = (sum_status_reg & ~sum_clear) | sum_hit;
		err_event_next = |sum_hit;
		err_class_next = LED_CLS_NONE;
		if (sum_hit[`LED_SUM_FATAL]) begin
			err_class_next = LED_CLS_FATAL;
		end else if (sum_hit[`LED_SUM_NONFATAL]) begin
			err_class_next = LED_CLS_NONFATAL;
		end else if (sum_hit[`LED_SUM_COR]) begin
			err_class_next = LED_CLS_COR;
		end
	end

	// Register all state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			replay_prev_reg <= '0;
			cor_status_reg <= `LED_COR_RST;
			unc_status_reg <= `LED_UNC_RST;
			sum_status_reg <= `LED_SUM_RST;
			err_event_reg <= 1'b0;
			err_class_reg <= LED_CLS_NONE;
		end else begin
			replay_prev_reg <= replay_prev_next;
			cor_status_reg <= cor_status_next;
			unc_status_reg <= unc_status_next;
			sum_status_reg <= sum_status_next;
			err_event_reg <= err_event_next;
			err_class_reg <= err_class_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_lane_fault: assert property (
		aer_enable && |lane_fault
		|=> cor_status_reg[`LED_COR_RX_PORT] && err_class_reg != LED_CLS_NONE)
		else $error("lane fault not logged");
	chk_code_set: assert property (
		lane_active[0] && rx_status[`LED_RXS_W-1] |-> lane_fault[0])
		else $error("receive status code not flagged");
	chk_deskew_ctrl: assert property (
		aer_enable && (deskew_ovfl || ctrl_sym_bad_lane) |=> cor_status_reg[`LED_COR_RX_PORT])
		else $error("deskew or control symbol fault not logged");
	chk_bad_tlp: assert property (
		aer_enable && (tlp_lcrc_bad || tlp_seq_bad) |=> cor_status_reg[`LED_COR_BAD_TLP])
		else $error("bad packet not logged");
	chk_bad_dllp: assert property (
		aer_enable && dllp_crc_bad |=> cor_status_reg[`LED_COR_BAD_DLLP])
		else $error("bad link packet not logged");
	chk_replay_tmr: assert property (
		replay_timeout |=> err_event_reg && sum_status_reg[`LED_SUM_COR])
		else $error("replay timeout not reported");
	chk_replay_wrap: assert property (
		aer_enable && (&replay_count) ##1 (aer_enable && replay_count == '0)
		|=> cor_status_reg[`LED_COR_REPLAY_ROLL])
		else $error("replay rollover not logged");
	chk_ack_window: assert property (
		ack_valid && acknowledged_sequence_number == next_tx_seq && last_acked_seq != next_tx_seq
		|=> err_event_reg && err_class_reg == LED_CLS_FATAL)
		else $error("ack beyond sent packets not fatal");
	chk_ack_legal: assert property (
		ack_valid && acknowledged_sequence_number == last_acked_seq
		&& !sum_status_reg[`LED_SUM_FATAL] && !sum_clear[`LED_SUM_FATAL]
		|=> !sum_status_reg[`LED_SUM_FATAL])
		else $error("duplicate ack wrongly flagged");
	chk_sticky: assert property (
		sum_status_reg[`LED_SUM_COR] && !sum_clear[`LED_SUM_COR]
		|=> sum_status_reg[`LED_SUM_COR])
		else $error("summary bit lost without clear");
	chk_clear_bit: assert property (
		aer_enable && replay_timeout && cor_clear[`LED_COR_REPLAY_TMR]
		|=> cor_status_reg[`LED_COR_REPLAY_TMR])
		else $error("set lost to simultaneous clear");
	chk_event_class: assert property (
		err_event_reg == (err_class_reg != LED_CLS_NONE))
		else $error("event and class disagree");

	cov_rx_fault: cover property (|lane_fault ##1 err_event_reg);
	cov_fatal: cover property (err_event_reg && err_class_reg == LED_CLS_FATAL);
	cov_rollover: cover property (replay_roll ##1 cor_status_reg[`LED_COR_REPLAY_ROLL]);
	cov_clear: cover property (sum_status_reg[`LED_SUM_COR] ##1 !sum_status_reg[`LED_SUM_COR]);

endmodule

// File: sim/led_phy_model.sv
`timescale 1ns/1ps
`include "led_regs.svh"

// ----------------------------------------
// Transceiver lane status model
// ----------------------------------------
module led_phy_model #(
	parameter int LANES = 8
) (
	// Commands from the bench
	input wire logic [`LED_RXS_W-1:0] code,
	input wire logic [LANES-1:0] sel,
	input wire logic go,
	input wire logic [LANES-1:0] act,
	// Lane status toward the block
	output logic [LANES*`LED_RXS_W-1:0] rx_status,
	output logic [LANES-1:0] lane_active
);
	// Selected lanes report the code, others report clean data
	always_comb begin
		lane_active = act;
		for (int n = 0; n < LANES; n++) begin
			rx_status[n*3+:3] = (go && sel[n]) ? code : 3'h0;
		end
	end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "led_regs.svh"

module testbench
	import led_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys = 1'h0, rst = 1'h1, go = 1'h0, ack_valid = 1'h0, aer_enable = 1'h1;
	logic [2:0] code = 3'h0, sum_clear = 3'h0, sum_status_reg;
	logic [7:0] sel = 8'h81, act = 8'hFF, lane_active;
	logic [23:0] rx_status;
	logic [5:0] src = 6'h00;
	logic [1:0] replay_count = 2'h0;
	logic [11:0] seq = 12'h000, last_seq = 12'h000, next_seq = 12'h001;
	logic [4:0] cor_clear = 5'h00, cor_status_reg;
	logic [0:0] unc_clear = 1'h0, unc_status_reg;
	logic err_event_reg;
	led_class_e err_class_reg;
	int err_total = 0, comparisons = 0, cycles = 0;

	// Clock and cycle ceiling
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			stop_test();
		end
	end

	led_phy_model #(.LANES(8)) led_phy_model_i (.code(code), .sel(sel), .go(go),
		.act(act), .rx_status(rx_status), .lane_active(lane_active));
	led_top #(.LANES(8), .REPLAY_W(2)) led_top_i (.clk_sys(clk_sys), .rst(rst),
		.rx_status(rx_status), .lane_active(lane_active), .deskew_ovfl(src[0]),
		.ctrl_sym_bad_lane(src[1]), .tlp_lcrc_bad(src[2]), .tlp_seq_bad(src[3]),
		.dllp_crc_bad(src[4]), .replay_timeout(src[5]), .replay_count(replay_count),
		.ack_valid(ack_valid), .acknowledged_sequence_number(seq),
		.last_acked_seq(last_seq), .next_tx_seq(next_seq), .aer_enable(aer_enable),
		.cor_clear(cor_clear), .unc_clear(unc_clear), .sum_clear(sum_clear),
		.cor_status_reg(cor_status_reg), .unc_status_reg(unc_status_reg),
		.sum_status_reg(sum_status_reg), .err_event_reg(err_event_reg),
		.err_class_reg(err_class_reg));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic step();
		@(negedge clk_sys);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Event, class, correctable and summary status after one edge
	task automatic evt(input logic [1:0] cls, input logic [4:0] cor, input logic [2:0] sum);
		chk(err_event_reg, cls != 2'h0);
		chk(err_class_reg, cls);
		chk(cor_status_reg, cor);
		chk(sum_status_reg, sum);
	endtask

	task automatic clr();
		cor_clear = 5'h1F;
		unc_clear = 1'h1;
		sum_clear = 3'h7;
		step();
		cor_clear = 5'h00;
		unc_clear = 1'h0;
		sum_clear = 3'h0;
		step();
	endtask

	task automatic ack(input logic [11:0] l, input logic [11:0] n, input logic [11:0] s);
		last_seq = l;
		next_seq = n;
		seq = s;
		ack_valid = 1'h1;
		step();
		ack_valid = 1'h0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_lanes();
		for (int c = 0; c < 8; c++) begin
			code = c[2:0];
			go = 1'h1;
			step();
			go = 1'h0;
			evt(c >= 4 ? 2'h1 : 2'h0, c >= 4 ? 5'h01 : 5'h00, c >= 4 ? 3'h1 : 3'h0);
			clr();
		end
		act = 8'h7E;
		code = 3'h4;
		go = 1'h1;
		step();
		go = 1'h0;
		act = 8'hFF;
		evt(2'h0, 5'h00, 3'h0);
	endtask

	task automatic t_pulses();
		logic [4:0] map [6] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h08};
		for (int i = 0; i < 6; i++) begin
			src = 6'h01 << i;
			step();
			src = 6'h00;
			evt(2'h1, map[i], 3'h1);
			clr();
		end
	endtask

	task automatic t_roll();
		replay_count = 2'h3;
		step();
		replay_count = 2'h0;
		step();
		evt(2'h1, 5'h10, 3'h1);
		clr();
	endtask

	task automatic t_ack();
		ack(12'h005, 12'h008, 12'h007);
		evt(2'h0, 5'h00, 3'h0);
		step();
		ack(12'hFFE, 12'h002, 12'h001);
		evt(2'h0, 5'h00, 3'h0);
		step();
		src = 6'h04;
		ack(12'h005, 12'h008, 12'h009);
		src = 6'h00;
		evt(2'h3, 5'h02, 3'h5);
		chk(unc_status_reg, 8'h01);
		step();
		evt(2'h0, 5'h02, 3'h5);
		clr();
		chk(unc_status_reg, 8'h00);
		// Duplicate of the last acked number is legal, one past the newest sent is not
		ack(12'h005, 12'h008, 12'h005);
		evt(2'h0, 5'h00, 3'h0);
		step();
		ack(12'h005, 12'h008, 12'h008);
		evt(2'h3, 5'h00, 3'h4);
		chk(unc_status_reg, 8'h01);
		clr();
	endtask

	task automatic t_aer_clr();
		aer_enable = 1'h0;
		src = 6'h10;
		step();
		src = 6'h00;
		aer_enable = 1'h1;
		evt(2'h1, 5'h00, 3'h1);
		step();
		// Replay timeout in the same cycle as its clear: the set wins
		sum_clear = 3'h1;
		cor_clear = 5'h08;
		src = 6'h20;
		step();
		src = 6'h00;
		cor_clear = 5'h00;
		evt(2'h1, 5'h08, 3'h1);
		step();
		sum_clear = 3'h0;
		evt(2'h0, 5'h08, 3'h0);
	endtask

	task automatic stop_test();
		$display("err_total %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) step();
		rst = 1'h0;
		step();
		evt(2'h0, 5'h00, 3'h0);
		t_lanes();
		t_pulses();
		t_roll();
		t_ack();
		t_aer_clr();
		stop_test();
	end
endmodule
